// *** fsc_defines.svh ***
// Purpose: constants for the field-rate side-channel framer
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   definitions only
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

// block geometry
`define FSC_BLK_BITS     312
`define FSC_LAST_IDX     9'd311
`define FSC_SYNC_WORD    16'hb847
`define FSC_PP_OFF       1'b1
`define FSC_PP_FILL      16'hffff
`define FSC_RSV3         3'b111
`define FSC_RSV2         2'b11
`define FSC_RSV12        12'hfff

// system mode codes
`define FSC_MODE_LEGACY  4'h0
`define FSC_MODE_MFN     4'h1
`define FSC_MODE_SFN     4'h2
`define FSC_MODE_MFN_MH  4'h9
`define FSC_MODE_SFN_MH  4'ha
`define FSC_MH_HOLD      4'd8

// register byte offsets
`define FSC_A_CTRL       8'h00
`define FSC_A_MODE       8'h04
`define FSC_A_RSV0       8'h08
`define FSC_A_RSV1       8'h0c
`define FSC_A_RSV2       8'h10
`define FSC_A_PAR0       8'h14
`define FSC_A_PAR1       8'h18
`define FSC_A_PAR2       8'h1c
`define FSC_A_PAR3       8'h20
`define FSC_A_STAT       8'h24

// control register fields
`define FSC_C_EN         0
`define FSC_C_VER_LO     4
`define FSC_C_VER_HI     8
`define FSC_C_MODE_LO    12
`define FSC_C_MODE_HI    15
`define FSC_C_CH_LO      16
`define FSC_C_CH_HI      18
`define FSC_C_PRI_LO     20
`define FSC_C_PRI_HI     22

// status register fields
`define FSC_S_BUSY       0
`define FSC_S_SHORT      1
`define FSC_S_BADMODE    2
`define FSC_S_IDX_LO     16
`define FSC_S_IDX_HI     24

`endif

// *** fsc_exciter_model.sv ***
// Purpose: exciter-side receiver of the side-channel bits
// Assumes: one bit per packet, qualified by side_bit_valid
// Notes:   keeps the bits of the latest block, first bit at msb
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.svh"

module fsc_exciter_model
  import fsc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       side_bit,
  input  wire logic       side_bit_valid,
  input  wire logic       block_start,
  output fsc_blk_t        rx_blk_q,   // bits in arrival order
  output logic      [8:0] rx_cnt_q,   // bits since block start
  output logic            tei_q       // error indicator, always cleared
);
  logic [115:0] sym_q;    // symbols for the next field sync
  logic [115:0] adopt_q;  // mode adopted one field later
  logic [4:0]   ver_rx_q; // version, decoded before later fields
  logic         odd_q;    // field parity for the level mapping
  logic [115:0] pos_q;    // one where the symbol goes to plus five

  // version taken as soon as its last bit arrives, ahead of any later field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ver_rx_q <= 5'h00;
    end else if (side_bit_valid && rx_cnt_q == 9'h014) begin
      ver_rx_q <= {rx_blk_q[3:0], side_bit};
    end
  end

  // shift in each bit; block start realigns the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_blk_q <= '0;
      rx_cnt_q <= 9'h000;
    end else if (side_bit_valid) begin
      rx_blk_q <= {rx_blk_q[`FSC_BLK_BITS-2:0], side_bit};
      rx_cnt_q <= block_start ? 9'h001 : rx_cnt_q + 9'h001;
    end
  end

  // on the last bit, mode and reserved symbols go to the next sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_q   <= '0;
      adopt_q <= '0;
      pos_q   <= '0;
      odd_q   <= 1'b1;
    end else if (side_bit_valid && rx_cnt_q == 9'h137) begin
      sym_q   <= rx_blk_q[270:155];
      adopt_q <= sym_q;
      // odd fields: one maps to plus five; even fields swap the levels
      pos_q   <= odd_q ? rx_blk_q[270:155] : ~rx_blk_q[270:155];
      odd_q   <= ~odd_q;
    end
  end

  // slot is cleared once the bit is taken out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tei_q <= 1'b0;
    end else begin
      tei_q <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// *** fsc_framer.sv ***
// Contract
// - 23 payload bytes, msb first, sync first
// - 16 parity bytes follow the 23 data
// - one 39-byte block per 312-packet field
// - block opens with sync word b847
// - version: 2-bit major over 3-bit minor
// - version starts zero, rises monotonically
// - fixed field order through parity
// - system mode codes 0,1,2,9,a only
// - hold mobile mode eight frames through gaps
// - post-processor flag always sent as one
// - post-processor control all ones
// - three channel flags, one means active
// - primary channel 0..2, rest reserved
// - parity covers all 23 payload bytes
// - one bit per packet error-indicator slot
// - first bit after sync point, last before
//
// Purpose: sender of the field-rate side channel, APB programmed
// Assumes: pkt_tick and csp_tick come from logic on pclk
// Notes:   parity is computed by software and written to PAR0..3
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.svh"

module fsc_framer
  import fsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pkt_tick,       // one pulse per transport packet
  input  wire logic        csp_tick,       // cadence sync point marker
  input  wire logic        mh_frame_tick,  // mobile frame boundary
  output logic             side_bit,       // bit for the error-indicator slot
  output logic             side_bit_valid, // pulse, with side_bit
  output logic             block_start     // pulse on the first bit of a block
);

  // register state
  logic        en_q;              // framer enable
  logic [4:0]  ver_q;             // version field
  logic [3:0]  mode_q;            // programmed system mode
  logic [2:0]  chan_q;            // channel activity flags
  logic [2:0]  prim_q;            // primary channel code
  logic [23:0] mbits_q;           // mode symbol bits
  logic [95:0] rsv_q;             // reserved symbol bits, low 92 used
  logic [127:0] par_q;            // parity bytes from software
  logic        short_q;           // sticky: field cut short by early sync point
  logic        badmode_q;         // sticky: reserved mode code write refused
  logic [3:0]  mh_last_q;         // last mobile mode programmed
  logic        mh_seen_q;         // a mobile mode has been programmed
  logic [3:0]  hold_q;            // mobile frames counted since leaving mobile
  fsc_state_e  st_q;              // framer state
  fsc_blk_t    blk_q;             // block being shifted out
  logic [8:0]  idx_q;             // bits already sent
  logic [31:0] rd_d;              // read mux

  wire         wr_acc = psel & penable & pwrite & pready;  // write takes effect here
  wire         mode_wr = wr_acc && (paddr == `FSC_A_CTRL);

  // legal sender mode codes; reserved ones never leave the block
  function automatic logic mode_ok(input logic [3:0] m);
    mode_ok = (m == `FSC_MODE_LEGACY) || (m == `FSC_MODE_MFN) || (m == `FSC_MODE_SFN) ||
              (m == `FSC_MODE_MFN_MH) || (m == `FSC_MODE_SFN_MH);
  endfunction

  function automatic logic is_mh(input logic [3:0] m);
    is_mh = (m == `FSC_MODE_MFN_MH) || (m == `FSC_MODE_SFN_MH);
  endfunction

  // version may not move back: major up, or minor up or unchanged under same major
  function automatic logic ver_ok(input logic [4:0] o, input logic [4:0] n);
    ver_ok = (n[4:3] > o[4:3]) || ((n[4:3] == o[4:3]) && (n[2:0] >= o[2:0]));
  endfunction

  wire [4:0] ver_w  = pwdata[`FSC_C_VER_HI:`FSC_C_VER_LO];
  wire [3:0] mode_w = pwdata[`FSC_C_MODE_HI:`FSC_C_MODE_LO];
  wire [2:0] prim_w = pwdata[`FSC_C_PRI_HI:`FSC_C_PRI_LO];

  // mode actually sent: stays mobile while mobile data may resume
  wire [3:0] mode_tx = (!is_mh(mode_q) && mh_seen_q && hold_q <= `FSC_MH_HOLD) ?
                       mh_last_q : mode_q;

  // control register; reserved codes are refused whole field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q   <= 1'b0;
      ver_q  <= 5'h00;
      mode_q <= `FSC_MODE_LEGACY;
      chan_q <= 3'h0;
      prim_q <= 3'h0;
    end else if (mode_wr) begin
      en_q   <= pwdata[`FSC_C_EN];
      chan_q <= pwdata[`FSC_C_CH_HI:`FSC_C_CH_LO];
      if (ver_ok(ver_q, ver_w)) begin
        ver_q <= ver_w;
      end
      if (mode_ok(mode_w)) begin
        mode_q <= mode_w;
      end
      if (prim_w <= 3'h2) begin
        prim_q <= prim_w;
      end
    end
  end

  // data registers for symbols and parity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbits_q <= 24'h000000;
      rsv_q   <= 96'h0;
      par_q   <= 128'h0;
    end else if (wr_acc) begin
      case (paddr)
        `FSC_A_MODE: mbits_q        <= pwdata[23:0];
        `FSC_A_RSV0: rsv_q[95:64]   <= pwdata;
        `FSC_A_RSV1: rsv_q[63:32]   <= pwdata;
        `FSC_A_RSV2: rsv_q[31:0]    <= pwdata;
        `FSC_A_PAR0: par_q[127:96]  <= pwdata;
        `FSC_A_PAR1: par_q[95:64]   <= pwdata;
        `FSC_A_PAR2: par_q[63:32]   <= pwdata;
        `FSC_A_PAR3: par_q[31:0]    <= pwdata;
        default: ;
      endcase
    end
  end

  // mobile hold tracking, counts frame ticks once software leaves mobile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mh_last_q <= `FSC_MODE_MFN_MH;
      mh_seen_q <= 1'b0;
      hold_q    <= 4'h0;
    end else if (is_mh(mode_q)) begin
      mh_last_q <= mode_q;
      mh_seen_q <= 1'b1;
      hold_q    <= 4'h0;
    end else if (mh_frame_tick && hold_q <= `FSC_MH_HOLD) begin
      hold_q <= hold_q + 4'h1;
    end
  end

  // sticky status; a new event beats a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_q   <= 1'b0;
      badmode_q <= 1'b0;
    end else begin
      if (st_q == FSC_SEND && csp_tick) begin
        short_q <= 1'b1;
      end else if (wr_acc && paddr == `FSC_A_STAT && pwdata[`FSC_S_SHORT]) begin
        short_q <= 1'b0;
      end
      if (mode_wr && !mode_ok(mode_w)) begin
        badmode_q <= 1'b1;
      end else if (wr_acc && paddr == `FSC_A_STAT && pwdata[`FSC_S_BADMODE]) begin
        badmode_q <= 1'b0;
      end
    end
  end

  // block assembly, captured whole at the sync point so a field never mixes settings
  wire fsc_blk_t blk_new = {`FSC_SYNC_WORD, ver_q, `FSC_RSV3, mode_tx, `FSC_PP_OFF,
                            `FSC_RSV3, chan_q, `FSC_RSV2, prim_q, mbits_q, rsv_q[91:0],
                            `FSC_PP_FILL, `FSC_RSV12, par_q};

  // framer: arms at each sync point while enabled, one bit per packet, stops after the last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= FSC_IDLE;
      blk_q <= '1;
      idx_q <= 9'h000;
    end else if (csp_tick && en_q) begin
      st_q  <= FSC_SEND;
      blk_q <= blk_new;
      idx_q <= 9'h000;
    end else if (csp_tick) begin
      st_q <= FSC_IDLE;
    end else if (st_q == FSC_SEND && pkt_tick) begin
      blk_q <= {blk_q[`FSC_BLK_BITS-2:0], 1'b1};
      idx_q <= idx_q + 9'h001;
      if (idx_q == `FSC_LAST_IDX) begin
        st_q <= FSC_IDLE;
      end
    end
  end

  // link outputs, registered; idle slots carry zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      side_bit       <= 1'b0;
      side_bit_valid <= 1'b0;
      block_start    <= 1'b0;
    end else begin
      side_bit_valid <= (st_q == FSC_SEND) && pkt_tick && !csp_tick;
      side_bit       <= (st_q == FSC_SEND) && pkt_tick && !csp_tick && blk_q[`FSC_BLK_BITS-1];
      block_start    <= (st_q == FSC_SEND) && pkt_tick && !csp_tick && (idx_q == 9'h000);
    end
  end

  // read mux
  always_comb begin
    rd_d = 32'h0;
    case (paddr)
      `FSC_A_CTRL: begin
        rd_d[`FSC_C_EN] = en_q;
        rd_d[`FSC_C_VER_HI:`FSC_C_VER_LO]   = ver_q;
        rd_d[`FSC_C_MODE_HI:`FSC_C_MODE_LO] = mode_q;
        rd_d[`FSC_C_CH_HI:`FSC_C_CH_LO]     = chan_q;
        rd_d[`FSC_C_PRI_HI:`FSC_C_PRI_LO]   = prim_q;
      end
      `FSC_A_MODE: rd_d = {8'h00, mbits_q};
      `FSC_A_RSV0: rd_d = {4'h0, rsv_q[91:64]};
      `FSC_A_RSV1: rd_d = rsv_q[63:32];
      `FSC_A_RSV2: rd_d = rsv_q[31:0];
      `FSC_A_PAR0: rd_d = par_q[127:96];
      `FSC_A_PAR1: rd_d = par_q[95:64];
      `FSC_A_PAR2: rd_d = par_q[63:32];
      `FSC_A_PAR3: rd_d = par_q[31:0];
      `FSC_A_STAT: begin
        rd_d[`FSC_S_BUSY]    = (st_q == FSC_SEND);
        rd_d[`FSC_S_SHORT]   = short_q;
        rd_d[`FSC_S_BADMODE] = badmode_q;
        rd_d[`FSC_S_IDX_HI:`FSC_S_IDX_LO] = idx_q;
      end
      default: rd_d = 32'h0;
    endcase
  end

  // apb answer: ready in the first access cycle, error on unmapped or unaligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ((paddr > `FSC_A_STAT) || (paddr[1:0] != 2'b00));
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // checks; block bit 311 is the first bit sent, so field positions count down from it
  sync_head_a: assert property (@(posedge pclk) disable iff (!presetn)
    (csp_tick && en_q) |=> blk_q[311:296] == `FSC_SYNC_WORD)
    else $error("block does not open with the sync word");
  first_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == FSC_SEND && idx_q == 9'h000 && pkt_tick && !csp_tick) |=> (block_start && side_bit))
    else $error("first bit sent is not the sync msb");
  field_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == FSC_SEND && pkt_tick && !csp_tick && idx_q == `FSC_LAST_IDX) |=> st_q == FSC_IDLE)
    else $error("block longer than one field");
  idx_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    idx_q <= 9'd312)
    else $error("bit index past block end");
  pp_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
    (csp_tick && en_q) |=> (blk_q[283] == `FSC_PP_OFF && blk_q[155:140] == `FSC_PP_FILL))
    else $error("post-processor bits not all ones");
  rsv_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
    (csp_tick && en_q) |=> (blk_q[290:288] == `FSC_RSV3 && blk_q[282:280] == `FSC_RSV3 &&
                            blk_q[276:275] == `FSC_RSV2 && blk_q[139:128] == `FSC_RSV12))
    else $error("reserved bits not ones");
  ver_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    (csp_tick && en_q) |=> blk_q[295:291] == $past(ver_q))
    else $error("version field misplaced in block");
  mode_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    (csp_tick && en_q) |=> blk_q[287:284] == $past(mode_tx))
    else $error("system mode field misplaced in block");
  ver_mono_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ver_ok($past(ver_q), ver_q))
    else $error("version went backwards");
  mode_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_ok(mode_tx) && prim_q <= 3'h2)
    else $error("reserved mode or channel code sent");
  mh_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (is_mh(mode_q) ##1 !is_mh(mode_q)) |-> is_mh(mode_tx))
    else $error("mobile mode dropped without hold");
  slot_align_a: assert property (@(posedge pclk) disable iff (!presetn)
    side_bit_valid |-> $past(pkt_tick) && !$past(csp_tick))
    else $error("bit sent outside a packet slot");
  idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !side_bit_valid |-> !side_bit)
    else $error("bit driven in an idle slot");

  full_block_c: cover property (@(posedge pclk) disable iff (!presetn)
    st_q == FSC_SEND && pkt_tick && idx_q == `FSC_LAST_IDX);
  short_field_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(short_q));
  mh_hold_c: cover property (@(posedge pclk) disable iff (!presetn)
    !is_mh(mode_q) && is_mh(mode_tx) && mh_frame_tick);
  bad_mode_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(badmode_q));

endmodule

`default_nettype wire

// *** fsc_framer_test.sv ***
// Purpose: self-checking bench of the side-channel framer
// Assumes: zero-wait apb slave, ticks driven on pclk
// Notes:   block contents checked through the exciter model
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.svh"

module fsc_framer_test;
  import fsc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic        pkt_tick, csp_tick, mh_frame_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, side_bit, side_bit_valid, block_start;
  fsc_blk_t    rx_blk;
  logic [8:0]  rx_cnt;
  logic [4:0]  ver;
  logic [4:0]  vt [3] = '{5'b00111, 5'b01001, 5'b01011};  // back, back, forward
  logic [3:0]  md [5] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'h9};  // legal modes
  int          err_count, num_checks;

  fsc_framer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pkt_tick(pkt_tick), .csp_tick(csp_tick), .mh_frame_tick(mh_frame_tick),
    .side_bit(side_bit), .side_bit_valid(side_bit_valid), .block_start(block_start));
  fsc_exciter_model exc (.pclk(pclk), .presetn(presetn), .side_bit(side_bit),
    .side_bit_valid(side_bit_valid), .block_start(block_start), .rx_blk_q(rx_blk),
    .rx_cnt_q(rx_cnt), .tei_q());

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_blk(input fsc_blk_t got, input fsc_blk_t exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after an edge; ends after an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) err_count++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd & m, x);
  endtask

  function automatic logic [31:0] ctl(input logic [4:0] v, input logic [3:0] m, input logic [2:0] p);
    return {9'h0, p, 1'b0, 3'b101, m, 3'h0, v, 3'h0, 1'b1};
  endfunction

  // cadence sync point, then n back-to-back packets
  task automatic send(input int n);
    csp_tick <= 1'b1;
    @(posedge pclk);
    csp_tick <= 1'b0;
    pkt_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    pkt_tick <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic frames(input int k);
    repeat (k) begin
      mh_frame_tick <= 1'b1;
      @(posedge pclk);
      mh_frame_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // about 1440 cycles expected; far beyond that means a hang
  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, pkt_tick, csp_tick, mh_frame_tick} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`FSC_A_CTRL, 32'hffffffff, 32'h0);
    rdc(`FSC_A_STAT, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h02, 32'h0);
    chk({31'h0, e}, 32'h1);
    // full block with extra packets past its end
    ver = 5'b01010;
    apb(1'b1, `FSC_A_CTRL, ctl(ver, `FSC_MODE_SFN, 3'd1));
    apb(1'b1, `FSC_A_MODE, 32'h00abcdef);
    apb(1'b1, `FSC_A_RSV0, 32'h01234567);
    apb(1'b1, `FSC_A_RSV1, 32'h89abcdef);
    apb(1'b1, `FSC_A_RSV2, 32'h02468ace);
    apb(1'b1, `FSC_A_PAR0, 32'h11223344);
    apb(1'b1, `FSC_A_PAR1, 32'h55667788);
    apb(1'b1, `FSC_A_PAR2, 32'h99aabbcc);
    apb(1'b1, `FSC_A_PAR3, 32'hddeeff00);
    send(320);
    chk_blk(rx_blk, {`FSC_SYNC_WORD, ver, 3'b111, 4'h2, 1'b1, 3'b111, 3'b101, 2'b11, 3'd1, 24'habcdef,
      28'h1234567, 64'h89abcdef_02468ace, 28'hfffffff, 128'h11223344_55667788_99aabbcc_ddeeff00});
    chk({23'h0, rx_cnt}, 32'd312);
    rdc(`FSC_A_STAT, 32'h01ff0000, 32'h01380000);
    // version may only move forward
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `FSC_A_CTRL, ctl(vt[i], `FSC_MODE_SFN, 3'd1));
      if (i == 2) ver = vt[i];
      rdc(`FSC_A_CTRL, 32'h000001f0, {23'h0, ver, 4'h0});
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `FSC_A_CTRL, ctl(ver, md[i], 3'd1));
      rdc(`FSC_A_CTRL, 32'h0000f000, {16'h0, md[i], 12'h0});
    end
    // reserved mode and primary codes leave the fields alone
    apb(1'b1, `FSC_A_CTRL, ctl(ver, 4'h5, 3'd3));
    rdc(`FSC_A_CTRL, 32'h0070f000, 32'h00109000);
    send(10);
    send(10);
    rdc(`FSC_A_STAT, 32'h00000007, 32'h00000007);
    apb(1'b1, `FSC_A_STAT, 32'h00000006);
    rdc(`FSC_A_STAT, 32'h00000006, 32'h0);
    // mobile code held for the current frame plus eight
    apb(1'b1, `FSC_A_CTRL, ctl(ver, `FSC_MODE_MFN, 3'd1));
    send(312);
    chk({28'h0, rx_blk[287:284]}, 32'h9);
    frames(8);
    send(312);
    chk({28'h0, rx_blk[287:284]}, 32'h9);
    frames(1);
    send(312);
    chk({28'h0, rx_blk[287:284]}, 32'h1);
    // reset again mid-run: registers, status and the receiver bit count return to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`FSC_A_CTRL, 32'hffffffff, 32'h0);
    rdc(`FSC_A_STAT, 32'hffffffff, 32'h0);
    chk({23'h0, rx_cnt}, 32'h0);
    finish_test();
  end
endmodule

`default_nettype wire

// *** fsc_pkg.sv ***
// Purpose: shared types of the side-channel framer
// Assumes: fsc_defines.svh holds the numbers
// Notes:   types only
`default_nettype none
`include "fsc_defines.svh"

package fsc_pkg;
  typedef enum logic [0:0] {FSC_IDLE, FSC_SEND} fsc_state_e;
  typedef logic [`FSC_BLK_BITS-1:0] fsc_blk_t;
endpackage

`default_nettype wire
